// ### cpm_cfg.svh
`ifndef CPM_CFG_SVH
`define CPM_CFG_SVH

// Register byte offsets
`define CPM_OFF_LOCK 8'h00
`define CPM_OFF_PLL 8'h04
`define CPM_OFF_USBPLL 8'h08
`define CPM_OFF_GATE 8'h0C
`define CPM_OFF_SLOW 8'h10
`define CPM_OFF_RATIO 8'h14
`define CPM_OFF_STATUS 8'h18

// Reset values
`define CPM_RST_LOCK 24'hFFFFFF
`define CPM_RST_PLL 20'h00000
`define CPM_RST_GATE 19'h7FFF8
`define CPM_RST_SLOW 8'h80
`define CPM_RST_RATIO 2'h0

// Field positions and peripheral gate count
`define CPM_LOCK_USB_HI 23
`define CPM_LOCK_USB_LO 12
`define CPM_LOCK_MAIN_HI 11
`define CPM_LOCK_MAIN_LO 0
`define CPM_GATE_STOP 0
`define CPM_GATE_IDLE 2
`define CPM_GATE_PER_LO 3
`define CPM_PERIPH_N 16
`define CPM_SLOW_VAL_HI 2
`define CPM_SLOW_BIT 4
`define CPM_SLOW_PLL_OFF 5
`define CPM_SLOW_USB_ON 7
`define CPM_RATIO_HALF_AHB 1
`define CPM_RATIO_HALF_APB 0

// Timing
`define CPM_CLK_MHZ 250
`define CPM_LOCK_MIN_US 150

`endif

// ### cpm_pkg.sv
package cpm_pkg;
`include "cpm_cfg.svh"

	typedef enum logic [2:0] {
		CPM_NORMAL = 3'b000,
		CPM_SLOW = 3'b001,
		CPM_IDLE_WAIT = 3'b010,
		CPM_IDLE = 3'b011,
		CPM_STOP = 3'b100,
		CPM_WAKE_LOCK = 3'b101,
		CPM_WAKE_DONE = 3'b110
	} cpm_mode_t;

	typedef enum logic [1:0] {
		CPM_USB_LOW = 2'b00,
		CPM_USB_REF = 2'b01,
		CPM_USB_48 = 2'b10
	} cpm_usb_src_t;

	// APB request and answer
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} cpm_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} cpm_apb_rsp_t;

	// Clock gating and selection outputs
	typedef struct packed {
		logic core_en;
		logic cpu_en;
		logic ahb_en;
		logic apb_en;
		logic core_src_pll;
		logic rtc_if_en;
		logic rtc_timer_en;
		logic main_pll_on;
		logic usb_pll_on;
		logic osc_on;
		cpm_usb_src_t usb_src;
		logic [`CPM_PERIPH_N-1:0] periph_en;
	} cpm_clk_out_t;

	typedef struct packed {
		cpm_mode_t mode;
		logic [23:0] lock_reg;
		logic [19:0] pll_cfg;
		logic [19:0] usb_cfg;
		logic [18:0] gate_reg;
		logic [7:0] slow_reg;
		logic [1:0] ratio_reg;
		logic [1:0] ratio_act;
		logic ratio_wait;
		logic ratio_hold;
		logic [1:0] ratio_dly;
		logic [1:0][11:0] lk_cnt;
		logic [1:0][15:0] lk_cyc;
		logic [1:0] lk_busy;
		logic pll_done;
		logic usb_done;
		logic [1:0] div_cnt;
		logic ahb_en;
		logic apb_en;
		logic [9:0] sync1;
		logic [9:0] sync2;
		logic ref_d;
		logic wake_irq;
		logic idle_req;
		logic [31:0] prdata;
	} cpm_state_t;
endpackage

// ### cpm_top.sv
// Behaviour
// R1 - PLL output unused until at least 150 us of lock time pass
// R2 - Lock wait inserted automatically after reset and STOP wake-up
// R3 - Lock wait lasts programmed count of reference clock periods, per PLL
// R4 - Core runs on reference clock until PLL configuration is written
// R5 - PLL relocks only on new setting; switch to PLL right after lock
// R6 - PLL rewrite in NORMAL starts lock wait; internal clocks stop meanwhile
// R7 - Two bits select AHB core or half, APB AHB or half
// R8 - Ratio written after PLL change takes effect after lock wait
// R9 - Otherwise ratio valid after 1.5 AHB periods, 1 from default
// R10 - USB clock low during USB lock wait, then 48 MHz
// R11 - USB PLL off in STOP; back on at exit if enabled
// R12 - USB clock is reference while USB PLL off or unconfigured
// R13 - NORMAL/SLOW run all clocks, IDLE stops CPU, STOP stops all
// R14 - STOP stops RTC bus clock, RTC timekeeping clock runs
// R15 - Peripheral clocks gateable; basic blocks stay clocked in NORMAL
// R16 - IDLE exits on external wake, RTC alarm or any interrupt
// R17 - STOP halts PLLs and oscillator; only NORMAL follows STOP
// R18 - STOP exit needs wake input, then clock gate rewrite
// R19 - Software prepares memory, LCD, masks and TLB before STOP
// R20 - External wake works even with all interrupts masked
// R21 - Core clock gated during wake lock, then wake interrupt raised
// R22 - Software passes through SLOW when changing PLL dividers
// R23 - SLOW mode core clock comes from reference input
// R24 - Lock register: USB count bits 23:12, main count 11:0
// R25 - Idle bit enters IDLE only after CPU wrapper acknowledge
// R26 - Only legal mode transitions are taken, others ignored
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`include "cpm_cfg.svh"
module cpm_top
	import cpm_pkg::*;
#(
	parameter int LOCK_MIN_CYC = `CPM_LOCK_MIN_US * `CPM_CLK_MHZ
)
(
	input wire logic mclk_in, // Block clock, 250 MHz
	input wire logic rst_n_in, // Synchronous reset, active low
	input wire cpm_apb_req_t apb_in, // APB request
	output cpm_apb_rsp_t apb_out, // APB answer
	input wire logic ref_clk_in, // Reference clock pin, sampled
	input wire logic [7:0] ext_wake_in, // External wake pins
	input wire logic rtc_alarm_in, // RTC alarm pin
	input wire logic irq_any_in, // Any pending interrupt
	input wire logic cpu_idle_ack_in, // CPU wrapper idle acknowledge
	output logic cpu_idle_req_out, // Idle request to CPU wrapper
	output logic wake_irq_out, // Wake-up interrupt pulse
	output cpm_clk_out_t clk_out, // Clock gates and selects
	output logic [19:0] pll_div_out, // Main PLL divider values
	output logic [19:0] usb_pll_div_out, // USB PLL divider values
	output logic [2:0] slow_div_out, // Slow clock divider
	output logic [1:0] ratio_out, // Active divide ratio
	output cpm_mode_t mode_out // Power mode
);

	localparam logic [15:0] LOCK_MIN = 16'(LOCK_MIN_CYC);

	cpm_state_t st;
	cpm_state_t next_st;

	localparam cpm_state_t ST_RST = '{
		mode: CPM_NORMAL,
		lock_reg: `CPM_RST_LOCK,
		pll_cfg: `CPM_RST_PLL,
		usb_cfg: `CPM_RST_PLL,
		gate_reg: `CPM_RST_GATE,
		slow_reg: `CPM_RST_SLOW,
		ratio_reg: `CPM_RST_RATIO,
		ratio_act: `CPM_RST_RATIO,
		ratio_wait: 1'b0,
		ratio_hold: 1'b1,
		ratio_dly: 2'h0,
		lk_cnt: {12'hFFF, 12'hFFF},
		lk_cyc: {16'h0000, 16'h0000},
		lk_busy: 2'h3,
		pll_done: 1'b0,
		usb_done: 1'b0,
		div_cnt: 2'h0,
		ahb_en: 1'b1,
		apb_en: 1'b1,
		sync1: 10'h000,
		sync2: 10'h000,
		ref_d: 1'b0,
		wake_irq: 1'b0,
		idle_req: 1'b0,
		prdata: 32'h00000000
	};

	logic wr;
	logic rd_setup;
	logic hit;
	logic ref_tick;
	logic ext_wake;
	logic rtc_wake;
	logic [1:0] lk_start;
	logic [1:0] lk_end;
	logic [11:0] lk_load [2];
	logic core_en;
	logic in_stop;
	logic main_lock_gate;
	logic usb_on;
	logic main_off;
	logic [31:0] rdata;

	// Decode and synchronised inputs
	always_comb
	begin
		wr = apb_in.psel & apb_in.penable & apb_in.pwrite;
		rd_setup = apb_in.psel & ~apb_in.penable;
		case (apb_in.paddr)
			`CPM_OFF_LOCK, `CPM_OFF_PLL, `CPM_OFF_USBPLL, `CPM_OFF_GATE,
			`CPM_OFF_SLOW, `CPM_OFF_RATIO, `CPM_OFF_STATUS: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		ref_tick = st.sync2[9] & ~st.ref_d;
		ext_wake = |st.sync2[7:0]; // R20
		rtc_wake = st.sync2[8];
		lk_load[0] = st.lock_reg[`CPM_LOCK_MAIN_HI:`CPM_LOCK_MAIN_LO]; // R24
		lk_load[1] = st.lock_reg[`CPM_LOCK_USB_HI:`CPM_LOCK_USB_LO]; // R24
		usb_on = st.slow_reg[`CPM_SLOW_USB_ON];
		main_off = st.slow_reg[`CPM_SLOW_PLL_OFF];
		in_stop = (st.mode == CPM_STOP) || (st.mode == CPM_WAKE_LOCK);
		// Clocks stop while the PLL relocks in NORMAL
		main_lock_gate = (st.mode == CPM_NORMAL) && st.pll_done
			&& st.lk_busy[0]; // R6
		core_en = ~in_stop & ~main_lock_gate; // R13 R21
		case (st.mode)
			CPM_IDLE_WAIT, CPM_IDLE: rdata = {29'h0, st.mode};
			default: rdata = {29'h0, st.mode};
		endcase
		case (apb_in.paddr)
			`CPM_OFF_LOCK: rdata = {8'h00, st.lock_reg};
			`CPM_OFF_PLL: rdata = {12'h000, st.pll_cfg};
			`CPM_OFF_USBPLL: rdata = {12'h000, st.usb_cfg};
			`CPM_OFF_GATE: rdata = {13'h0000, st.gate_reg};
			`CPM_OFF_SLOW: rdata = {24'h000000, st.slow_reg};
			`CPM_OFF_RATIO: rdata = {30'h0, st.ratio_reg};
			`CPM_OFF_STATUS: rdata = {23'h0, st.ratio_act, st.usb_done,
				st.pll_done, st.lk_busy, st.mode};
			default: rdata = 32'h00000000;
		endcase
	end

	// Next state of the whole block
	always_comb
	begin
		next_st = st;
		lk_start = 2'b00;
		// Pins pass two flops before use
		next_st.sync1 = {ref_clk_in, rtc_alarm_in, ext_wake_in};
		next_st.sync2 = st.sync1;
		next_st.ref_d = st.sync2[9];
		next_st.wake_irq = 1'b0;
		if (rd_setup)
			next_st.prdata = rdata;

		// Register writes take effect at the access edge
		if (wr)
		begin
			case (apb_in.paddr)
				`CPM_OFF_LOCK: next_st.lock_reg = apb_in.pwdata[23:0];
				`CPM_OFF_PLL:
				begin
					next_st.pll_cfg = apb_in.pwdata[19:0];
					next_st.pll_done = 1'b1; // R4
					next_st.ratio_hold = 1'b1; // R8
					if (st.mode != CPM_SLOW || !main_off)
						lk_start[0] = 1'b1; // R5 R6
				end
				`CPM_OFF_USBPLL:
				begin
					next_st.usb_cfg = apb_in.pwdata[19:0];
					next_st.usb_done = 1'b1;
					if (usb_on)
						lk_start[1] = 1'b1; // R10
				end
				`CPM_OFF_GATE:
				begin
					next_st.gate_reg = apb_in.pwdata[18:0];
					// A rewrite after wake-up completes the return
					if (st.mode == CPM_WAKE_DONE)
					begin
						next_st.gate_reg[`CPM_GATE_STOP] = 1'b0;
						next_st.gate_reg[`CPM_GATE_IDLE] = 1'b0;
					end
				end
				`CPM_OFF_SLOW:
				begin
					next_st.slow_reg = apb_in.pwdata[7:0];
					if (!usb_on && apb_in.pwdata[`CPM_SLOW_USB_ON])
						lk_start[1] = 1'b1; // R12
					// PLL restarts when turned back on in SLOW
					if (st.mode == CPM_SLOW && main_off
						&& !apb_in.pwdata[`CPM_SLOW_PLL_OFF])
						lk_start[0] = 1'b1;
				end
				`CPM_OFF_RATIO:
				begin
					next_st.ratio_reg = apb_in.pwdata[1:0]; // R7
					next_st.ratio_wait = 1'b1;
					// One AHB period from default, else 1.5 rounded up
					if (st.ratio_act == `CPM_RST_RATIO)
						next_st.ratio_dly = 2'd1; // R9
					else if (st.ratio_act[`CPM_RATIO_HALF_AHB])
						next_st.ratio_dly = 2'd3; // R9
					else
						next_st.ratio_dly = 2'd2; // R9
				end
				default: ;
			endcase
		end

		// Power mode sequencer; other requests are left pending
		case (st.mode)
			CPM_NORMAL:
			begin
				if (st.gate_reg[`CPM_GATE_STOP])
					next_st.mode = CPM_STOP; // R26
				else if (st.gate_reg[`CPM_GATE_IDLE])
				begin
					next_st.mode = CPM_IDLE_WAIT;
					next_st.idle_req = 1'b1;
				end
				else if (st.slow_reg[`CPM_SLOW_BIT])
					next_st.mode = CPM_SLOW; // R26
			end
			CPM_SLOW:
			begin
				// Leave only with the PLL on and locked
				if (!st.slow_reg[`CPM_SLOW_BIT] && !main_off
					&& !st.lk_busy[0] && !lk_start[0])
					next_st.mode = CPM_NORMAL; // R26
			end
			CPM_IDLE_WAIT:
			begin
				if (cpu_idle_ack_in)
				begin
					next_st.mode = CPM_IDLE; // R25
					next_st.idle_req = 1'b0;
				end
			end
			CPM_IDLE:
			begin
				if (ext_wake || rtc_wake || irq_any_in)
				begin
					next_st.mode = CPM_NORMAL; // R16
					next_st.gate_reg[`CPM_GATE_IDLE] = 1'b0;
				end
			end
			CPM_STOP:
			begin
				if (ext_wake || rtc_wake)
				begin
					next_st.mode = CPM_WAKE_LOCK; // R18
					next_st.ratio_hold = 1'b1; // R8
					lk_start[0] = 1'b1; // R2
					lk_start[1] = usb_on; // R11
				end
			end
			CPM_WAKE_LOCK:
			begin
				if (!st.lk_busy[0])
				begin
					next_st.mode = CPM_WAKE_DONE;
					next_st.wake_irq = 1'b1; // R21
				end
			end
			CPM_WAKE_DONE:
			begin
				if (wr && apb_in.paddr == `CPM_OFF_GATE)
					next_st.mode = CPM_NORMAL; // R17 R18
			end
			default: next_st.mode = CPM_NORMAL;
		endcase

		// Lock engines, one per PLL
		for (int i = 0; i < 2; i++)
		begin
			lk_end[i] = st.lk_busy[i] && (st.lk_cnt[i] == 12'h000)
				&& (st.lk_cyc[i] >= LOCK_MIN); // R1 R3
			if (lk_start[i])
			begin
				next_st.lk_busy[i] = 1'b1;
				next_st.lk_cnt[i] = lk_load[i]; // R3
				next_st.lk_cyc[i] = 16'h0000;
			end
			else if (lk_end[i])
				next_st.lk_busy[i] = 1'b0;
			else if (st.lk_busy[i])
			begin
				if (ref_tick && st.lk_cnt[i] != 12'h000)
					next_st.lk_cnt[i] = st.lk_cnt[i] - 12'h001; // R3
				if (st.lk_cyc[i] < LOCK_MIN)
					next_st.lk_cyc[i] = st.lk_cyc[i] + 16'h0001; // R1
			end
		end

		// Ratio update, held back behind a lock wait
		if (lk_end[0] && !lk_start[0])
			next_st.ratio_hold = 1'b0;
		// A fresh write restarts the countdown instead of being decremented
		if (st.ratio_wait && !(wr && apb_in.paddr == `CPM_OFF_RATIO))
		begin
			if (st.ratio_hold)
			begin
				if (lk_end[0] && !lk_start[0])
				begin
					next_st.ratio_act = st.ratio_reg; // R8
					next_st.ratio_wait = 1'b0;
				end
			end
			else if (st.ratio_dly <= 2'd1)
			begin
				next_st.ratio_act = st.ratio_reg; // R9
				next_st.ratio_wait = 1'b0;
			end
			else
				next_st.ratio_dly = st.ratio_dly - 2'd1;
		end
		if (wr && apb_in.paddr == `CPM_OFF_RATIO)
			next_st.ratio_wait = 1'b1;

		// AHB and APB enables from a divide counter
		next_st.div_cnt = st.div_cnt + 2'd1;
		next_st.ahb_en = core_en && (!st.ratio_act[`CPM_RATIO_HALF_AHB]
			|| next_st.div_cnt[0]); // R7
		case (st.ratio_act)
			2'b00: next_st.apb_en = core_en;
			2'b01, 2'b10: next_st.apb_en = core_en && next_st.div_cnt[0];
			2'b11: next_st.apb_en = core_en && (next_st.div_cnt == 2'd3);
			default: next_st.apb_en = core_en; // R7
		endcase
	end

	// State register
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			st <= ST_RST; // R2 R4 R12
		else
			st <= next_st;
	end

	// APB answer: no wait states, error on unmapped offsets
	assign apb_out.pready = 1'b1;
	assign apb_out.pslverr = apb_in.psel & apb_in.penable & ~hit;
	assign apb_out.prdata = st.prdata;

	// Clock gating and source selection
	always_comb
	begin
		clk_out.core_en = core_en; // R13
		clk_out.cpu_en = core_en && (st.mode != CPM_IDLE); // R13
		clk_out.ahb_en = st.ahb_en; // R15
		clk_out.apb_en = st.apb_en;
		// Reference until configured, in SLOW, and while relocking
		clk_out.core_src_pll = st.pll_done && !st.lk_busy[0]
			&& (st.mode != CPM_SLOW); // R4 R5 R23
		clk_out.rtc_if_en = ~in_stop; // R14
		clk_out.rtc_timer_en = 1'b1; // R14
		clk_out.main_pll_on = ~(st.mode == CPM_STOP)
			&& ~(st.mode == CPM_SLOW && main_off); // R17
		clk_out.usb_pll_on = (st.mode != CPM_STOP) && usb_on; // R11
		clk_out.osc_on = (st.mode != CPM_STOP); // R17
		if (in_stop)
			clk_out.usb_src = CPM_USB_LOW; // R13
		else if (!usb_on || !st.usb_done)
			clk_out.usb_src = CPM_USB_REF; // R12
		else if (st.lk_busy[1])
			clk_out.usb_src = CPM_USB_LOW; // R10
		else
			clk_out.usb_src = CPM_USB_48; // R10
		clk_out.periph_en = core_en ? st.gate_reg[18:`CPM_GATE_PER_LO]
			: '0; // R15
	end

	assign cpu_idle_req_out = st.idle_req;
	assign wake_irq_out = st.wake_irq;
	assign pll_div_out = st.pll_cfg;
	assign usb_pll_div_out = st.usb_cfg;
	assign slow_div_out = st.slow_reg[`CPM_SLOW_VAL_HI:0];
	assign ratio_out = st.ratio_act;
	assign mode_out = st.mode;

endmodule

// ### cpm_top_asserts.sv
`timescale 1ns/1ps
module cpm_top_asserts
	import cpm_pkg::*;
#(
	parameter int LOCK_MIN_CYC = 8
)
(
	input wire logic mclk_in, // Clock
	input wire logic rst_n_in, // Reset
	input wire cpm_apb_req_t apb_in, // APB request
	input wire cpm_apb_rsp_t apb_out, // APB answer
	input wire logic ref_clk_in, // Reference
	input wire logic [7:0] ext_wake_in, // Wake pins
	input wire logic rtc_alarm_in, // Alarm
	input wire logic irq_any_in, // Interrupt
	input wire logic cpu_idle_ack_in, // Idle ack
	input wire logic cpu_idle_req_out, // Idle req
	input wire logic wake_irq_out, // Wake pulse
	input wire cpm_clk_out_t clk_out, // Clock gates
	input wire logic [19:0] pll_div_out, // Main div
	input wire logic [19:0] usb_pll_div_out, // USB div
	input wire logic [2:0] slow_div_out, // Slow div
	input wire logic [1:0] ratio_out, // Ratio
	input wire cpm_mode_t mode_out // Mode
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);

	// Mode against clock gates, idle acknowledge and wake pulse; the cheapest net for a swapped mode code
	chk_stop_dark: assert property (mode_out == CPM_STOP |->
		!clk_out.core_en && !clk_out.osc_on && !clk_out.main_pll_on
		&& !clk_out.usb_pll_on) else $error("clock alive in stop");
	chk_rtc_split: assert property (mode_out == CPM_STOP |->
		!clk_out.rtc_if_en && clk_out.rtc_timer_en)
		else $error("rtc clocks wrong in stop");
	chk_idle_cpu: assert property (mode_out == CPM_IDLE |->
		!clk_out.cpu_en && clk_out.core_en) else $error("idle gating wrong");
	chk_idle_ack: assert property (mode_out == CPM_IDLE &&
		$past(mode_out) == CPM_IDLE_WAIT |-> $past(cpu_idle_ack_in))
		else $error("idle entered without ack");
	chk_wake_gate: assert property (mode_out == CPM_WAKE_LOCK |->
		!clk_out.core_en) else $error("core clock during wake lock");
	chk_wake_pulse: assert property (wake_irq_out |->
		mode_out == CPM_WAKE_DONE && $past(mode_out) == CPM_WAKE_LOCK
		##1 !wake_irq_out) else $error("wake pulse misplaced");

	// Legal paths into and out of the low power modes, then clock source and relock gap checks
	chk_stop_exit: assert property ($past(mode_out) == CPM_STOP &&
		mode_out != CPM_STOP |-> mode_out == CPM_WAKE_LOCK)
		else $error("illegal stop exit");
	chk_done_exit: assert property ($past(mode_out) == CPM_WAKE_DONE &&
		mode_out != CPM_WAKE_DONE |-> mode_out == CPM_NORMAL)
		else $error("illegal wake exit");
	chk_slow_entry: assert property (mode_out == CPM_SLOW &&
		$past(mode_out) != CPM_SLOW |-> $past(mode_out) == CPM_NORMAL)
		else $error("illegal slow entry");
	chk_slow_ref: assert property (mode_out == CPM_SLOW |->
		!clk_out.core_src_pll) else $error("pll used in slow");
	chk_usb_source: assert property (clk_out.usb_src == CPM_USB_48 |->
		clk_out.usb_pll_on) else $error("48 MHz with pll off");
	chk_relock_gate: assert property (apb_in.psel && apb_in.penable &&
		apb_in.pwrite && apb_in.paddr == 8'h04 && mode_out == CPM_NORMAL
		|=> ##[0:2] !clk_out.core_en) else $error("no relock gap");

	cover property (mode_out == CPM_IDLE);
	cover property (wake_irq_out);
	cover property (mode_out == CPM_SLOW);
endmodule

bind cpm_top cpm_top_asserts #(.LOCK_MIN_CYC(LOCK_MIN_CYC)) chk_u (
	.mclk_in(mclk_in), .rst_n_in(rst_n_in), .apb_in(apb_in),
	.apb_out(apb_out), .ref_clk_in(ref_clk_in), .ext_wake_in(ext_wake_in),
	.rtc_alarm_in(rtc_alarm_in), .irq_any_in(irq_any_in),
	.cpu_idle_ack_in(cpu_idle_ack_in), .cpu_idle_req_out(cpu_idle_req_out),
	.wake_irq_out(wake_irq_out), .clk_out(clk_out),
	.pll_div_out(pll_div_out), .usb_pll_div_out(usb_pll_div_out),
	.slow_div_out(slow_div_out), .ratio_out(ratio_out), .mode_out(mode_out)
);

// ### cpm_top_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) \
begin \
	comparisons++; \
	if ((a) !== (e)) \
	begin \
		num_errors++; \
		$display("mismatch %0t got %h exp %h", $time, a, e); \
	end \
end

module cpm_top_bench
	import cpm_pkg::*;
;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	cpm_apb_req_t apb_in = '0;
	cpm_apb_rsp_t apb_out;
	logic [1:0] ref_cnt = 2'h0;
	logic [7:0] ext_wake_in = 8'h00;
	logic rtc_alarm_in = 1'b0;
	logic irq_any_in = 1'b0;
	logic cpu_idle_ack_in = 1'b0;
	logic cpu_idle_req_out;
	logic wake_irq_out;
	cpm_clk_out_t clk_out;
	logic [19:0] pll_div_out;
	logic [19:0] usb_pll_div_out;
	logic [2:0] slow_div_out;
	logic [1:0] ratio_out;
	cpm_mode_t mode_out;
	logic [31:0] rdata;
	logic rerr;
	int num_errors = 0;
	int comparisons = 0;

	// 250 MHz clock; reference runs at a quarter of it
	always #2 mclk_in = ~mclk_in;
	always @(posedge mclk_in) ref_cnt <= ref_cnt + 2'h1;

	// Short minimum lock keeps the run brief
	cpm_top #(.LOCK_MIN_CYC(8)) dut_u (
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .apb_in(apb_in),
		.apb_out(apb_out), .ref_clk_in(ref_cnt[1]),
		.ext_wake_in(ext_wake_in), .rtc_alarm_in(rtc_alarm_in),
		.irq_any_in(irq_any_in), .cpu_idle_ack_in(cpu_idle_ack_in),
		.cpu_idle_req_out(cpu_idle_req_out), .wake_irq_out(wake_irq_out),
		.clk_out(clk_out), .pll_div_out(pll_div_out),
		.usb_pll_div_out(usb_pll_div_out), .slow_div_out(slow_div_out),
		.ratio_out(ratio_out), .mode_out(mode_out)
	);

	// One APB transfer; an idle edge first so release and setup never collide
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		apb_in <= '{1'b1, 1'b0, w, a, d};
		@(posedge mclk_in);
		apb_in.penable <= 1'b1;
		do
			@(posedge mclk_in);
		while (apb_out.pready !== 1'b1);
		rdata = apb_out.prdata;
		rerr = apb_out.pslverr;
		apb_in <= '0;
	endtask

	// Bounded wait for a mode, then compare
	task automatic wait_mode(input cpm_mode_t m);
		for (int n = 0; n < 300 && mode_out !== m; n++)
			@(posedge mclk_in);
		`CHK(mode_out, m)
	endtask

	task automatic complete_run;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Watchdog, far beyond the few hundred cycles the tests need
	initial
	begin
		#100000;
		num_errors++;
		complete_run;
	end

	// Test sequence
	initial
	begin
		int n;
		int ca;
		int cp;
		logic [1:0] old;
		repeat (4) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		`CHK(rdata, 32'h00FFFFFF)
		`CHK(clk_out.core_src_pll, 1'b0)
		`CHK(clk_out.usb_src, CPM_USB_REF)
		`CHK(ratio_out, 2'h0)
		apb(1'b0, 8'h1C, 32'h0);
		`CHK({rerr, rdata}, 33'h100000000)
		$display("test 1 done");
		// Main PLL relock with short counts
		apb(1'b1, 8'h00, 32'h00003005);
		apb(1'b1, 8'h04, 32'h00012345);
		@(posedge mclk_in);
		#1 `CHK(clk_out.core_en, 1'b0)
		for (n = 1; n < 200 && clk_out.core_src_pll !== 1'b1; n++)
			@(posedge mclk_in);
		`CHK(n >= 12 && n < 80, 1'b1)
		`CHK({clk_out.core_en, pll_div_out}, {1'b1, 20'h12345})
		$display("test 2 done");
		// USB clock low while locking, reference while off
		apb(1'b1, 8'h08, 32'h00054321);
		@(posedge mclk_in);
		#1 `CHK({clk_out.usb_src, usb_pll_div_out}, {CPM_USB_LOW, 20'h54321})
		for (n = 0; n < 200 && clk_out.usb_src !== CPM_USB_48; n++)
			@(posedge mclk_in);
		`CHK(clk_out.usb_src, CPM_USB_48)
		apb(1'b1, 8'h10, 32'h00000000);
		repeat (2) @(posedge mclk_in);
		#1 `CHK(clk_out.usb_src, CPM_USB_REF)
		apb(1'b1, 8'h10, 32'h00000080);
		for (n = 0; n < 200 && clk_out.usb_src !== CPM_USB_48; n++)
			@(posedge mclk_in);
		`CHK(clk_out.usb_src, CPM_USB_48)
		$display("test 3 done");
		// Every ratio, with its switch delay and enable rates
		old = 2'h0;
		for (int r = 1; r < 5; r++)
		begin
			n = (old == 2'h0) ? 1 : (old[1] ? 3 : 2);
			apb(1'b1, 8'h14, 32'(r % 4));
			repeat (n - 1) @(posedge mclk_in);
			#1 `CHK(ratio_out, old)
			@(posedge mclk_in);
			#1 `CHK(ratio_out, 2'(r % 4))
			old = 2'(r % 4);
			ca = 0;
			cp = 0;
			repeat (2) @(posedge mclk_in);
			for (int k = 0; k < 8; k++)
			begin
				@(posedge mclk_in);
				#1 ca += clk_out.ahb_en;
				cp += clk_out.apb_en;
			end
			`CHK(ca, old[1] ? 4 : 8)
			`CHK(cp, old == 2'h3 ? 2 : (old == 2'h0 ? 8 : 4))
		end
		// Ratio written after a relock waits for the lock to end
		apb(1'b1, 8'h04, 32'h00012345);
		apb(1'b1, 8'h14, 32'h00000003);
		repeat (4) @(posedge mclk_in);
		#1 `CHK(ratio_out, 2'h0)
		for (n = 0; n < 200 && clk_out.core_src_pll !== 1'b1; n++)
			@(posedge mclk_in);
		`CHK(ratio_out, 2'h3)
		$display("test 4 done");
		// Idle entry waits for the acknowledge
		apb(1'b1, 8'h0C, 32'h00055550);
		#1 `CHK({clk_out.periph_en, clk_out.core_en}, {16'hAAAA, 1'b1})
		apb(1'b1, 8'h0C, 32'h0007FFFC);
		repeat (6) @(posedge mclk_in);
		`CHK({mode_out, cpu_idle_req_out}, {CPM_IDLE_WAIT, 1'b1})
		cpu_idle_ack_in <= 1'b1;
		wait_mode(CPM_IDLE);
		`CHK({clk_out.cpu_en, clk_out.core_en}, 2'b01)
		cpu_idle_ack_in <= 1'b0;
		irq_any_in <= 1'b1;
		wait_mode(CPM_NORMAL);
		irq_any_in <= 1'b0;
		$display("test 5 done");
		// Stop, woken by a pin and then by the alarm
		for (int i = 0; i < 2; i++)
		begin
			irq_any_in <= 1'b0;
			apb(1'b1, 8'h0C, 32'h0007FFF9);
			wait_mode(CPM_STOP);
			apb(1'b1, 8'h10, i ? 32'h0 : 32'h80);
			repeat (20) @(posedge mclk_in);
			`CHK(mode_out, CPM_STOP)
			`CHK({clk_out.rtc_if_en, clk_out.rtc_timer_en, clk_out.osc_on, clk_out.periph_en}, {3'b010, 16'h0000})
			if (i == 0)
				ext_wake_in <= 8'h80;
			else
				rtc_alarm_in <= 1'b1;
			wait_mode(CPM_WAKE_LOCK);
			`CHK(clk_out.core_en, 1'b0)
			for (n = 0; n < 300 && wake_irq_out !== 1'b1; n++)
				@(posedge mclk_in);
			`CHK({wake_irq_out, mode_out}, {1'b1, CPM_WAKE_DONE})
			ext_wake_in <= 8'h00;
			rtc_alarm_in <= 1'b0;
			repeat (10) @(posedge mclk_in);
			`CHK({mode_out, clk_out.usb_pll_on}, {CPM_WAKE_DONE, i == 0})
			apb(1'b1, 8'h0C, 32'h0007FFF8);
			wait_mode(CPM_NORMAL);
		end
		$display("test 6 done");
		// Slow mode runs from the reference
		apb(1'b1, 8'h10, 32'h00000093);
		wait_mode(CPM_SLOW);
		`CHK({clk_out.core_src_pll, slow_div_out}, {1'b0, 3'h3})
		// Divider change while in SLOW keeps the core clock running
		apb(1'b1, 8'h04, 32'h0000ABCD);
		#1 `CHK(clk_out.core_en, 1'b1)
		apb(1'b1, 8'h10, 32'h00000080);
		@(posedge mclk_in);
		#1 `CHK(mode_out, CPM_SLOW)
		wait_mode(CPM_NORMAL);
		`CHK({clk_out.core_src_pll, pll_div_out}, {1'b1, 20'h0ABCD})
		$display("test 7 done");
		complete_run;
	end
endmodule
